// ---- hdl/rx_cond_pkg.sv ----
// Constants for the receive channel conditioning block
// Functional notes
// - Extract enable copies four signaling bits per channel
// - Extraction only while SF/ESF/SLC-96 synchronized
// - SF fills third, fourth fields with A,B
// - Signaling fields valid only with extract enabled
// - Indirect per-channel registers at three bases
// - Per-channel select only when global select zero
// - Decode none, trunk, A-law, mu-law milliwatt
// - Inversion codes 001, 010, 011 masks
// - Inversion codes 100 to 111 masks
// - Gapping only clock master with enable set
// - LSB gap or whole channel gap
// - Eight-bit data trunk code per channel
// - Signaling trunk enable replaces signaling with code
// - Test enable acts in 8 or 7 bit mode
// - Direction 0 detects, 1 overwrites from generator
// - Eight bits or seven MSBs tested
// - Enabled channels form one continuous stream
package rx_cond_pkg;
  localparam int NUM_CH = 24;
  // Bus map: paddr[10] picks the bank, paddr[9:2] is the index
  localparam int BANK_BIT = 10;
  localparam logic BANK_EXT  = 1'b0;
  localparam logic BANK_COND = 1'b1;
  localparam logic [7:0] IDX_STATUS = 8'h00;
  localparam logic [7:0] IDX_GLOBAL = 8'h00;
  localparam logic [7:0] BASE_CTRL = 8'h01;
  localparam logic [7:0] BASE_DTRK = 8'h21;
  localparam logic [7:0] BASE_STRK = 8'h41;
  // Extractor register fields
  localparam int EXT_EN_BIT = 4;
  localparam logic EXT_EN_RST = 1'b1;
  // Channel control fields
  localparam int CTRL_SEL_LSB = 5;
  localparam int CTRL_MSB_FLIP = 4;
  localparam int CTRL_ODD_FLIP = 3;
  localparam int CTRL_EVEN_FLIP = 2;
  localparam int CTRL_LSB_GAP = 1;
  localparam int CTRL_CH_GAP = 0;
  // Signaling trunk fields
  localparam int STRK_TEST_BIT = 6;
  localparam int STRK_EN_BIT = 4;
  // Global control fields
  localparam int GLB_SEL_LSB = 0;
  localparam int GLB_STRK_EN = 3;
  localparam int GLB_PER_CHANNEL_CLOCK_CONTROL_ENABLE = 4;
  localparam int GLB_PTW_LSB = 5;
  localparam int GLB_PTDIR = 7;
  localparam logic [7:0] GLB_RST = 8'h00;
  // Pattern test width modes
  localparam logic [1:0] PTW_OFF = 2'h0;
  localparam logic [1:0] PTW_8 = 2'h1;
  localparam logic [1:0] PTW_7 = 2'h2;
  // Receive frame formats
  localparam logic [1:0] FMT_SF = 2'h0;
  localparam logic [1:0] FMT_ESF = 2'h1;
  localparam logic [1:0] FMT_DM = 2'h2;
  localparam logic [1:0] FMT_SLC = 2'h3;
  // Replacement selections
  localparam logic [2:0] REPL_NONE = 3'h0;
  localparam logic [2:0] REPL_TRUNK = 3'h1;
  localparam logic [2:0] REPL_ALAW = 3'h2;
  localparam logic [2:0] REPL_ULAW = 3'h3;
  // Milliwatt sequences, first byte in the top bits
  localparam logic [63:0] MW_ALAW = 64'h34_21_21_34_b4_a1_a1_b4;
  localparam logic [63:0] MW_ULAW = 64'h1e_0b_0b_1e_9e_8b_8b_9e;
  // Inversion masks, bit 7 of a byte is channel bit 1
  localparam logic [7:0] MASK_MSB = 8'h80;
  localparam logic [7:0] MASK_ODD = 8'h2a;
  localparam logic [7:0] MASK_EVEN = 8'h55;
  localparam logic [7:0] MASK_LSB = 8'h01;
  localparam logic [7:0] MASK_ALL = 8'hff;
endpackage : rx_cond_pkg

// ---- hdl/channel_conditioner.sv ----
// Combinational per-byte substitution, inversion and pattern overwrite
`timescale 1ns/1ps
`default_nettype none
module channel_conditioner (
  input  wire logic [7:0] din,
  input  wire logic [2:0] repl_sel,
  input  wire logic [7:0] trunk_code,
  input  wire logic [2:0] mw_phase,
  input  wire logic       msb_flip,
  input  wire logic       odd_bit_flip,
  input  wire logic       even_bit_flip,
  input  wire logic       pat_replace,
  input  wire logic       pat_seven,
  input  wire logic [7:0] pat_data,
  output logic      [7:0] dout
);
  logic [7:0] subst;
  logic [7:0] flip_mask;
  logic [5:0] mw_pos;

  assign mw_pos = {~mw_phase, 3'h0} + 6'h0;

  always_comb
  begin
    case (repl_sel)
      rx_cond_pkg::REPL_TRUNK: subst = trunk_code;
      rx_cond_pkg::REPL_ALAW:  subst = rx_cond_pkg::MW_ALAW[mw_pos +: 8];
      rx_cond_pkg::REPL_ULAW:  subst = rx_cond_pkg::MW_ULAW[mw_pos +: 8];
      default:                 subst = din;
    endcase
  end

  // Masks combine by OR, which yields all eight documented codes
  assign flip_mask = (msb_flip ? rx_cond_pkg::MASK_MSB : 8'h00)
                   | (odd_bit_flip ? rx_cond_pkg::MASK_ODD : 8'h00)
                   | (even_bit_flip ? rx_cond_pkg::MASK_EVEN : 8'h00);

  always_comb
  begin
    dout = subst ^ flip_mask;
    if (pat_replace)
    begin
      // Seven-bit mode keeps the LSB of the substituted and inverted byte
      dout = pat_seven ? {pat_data[6:0], dout[0]} : pat_data;
    end
  end
endmodule : channel_conditioner
`default_nettype wire

// ---- hdl/rx_channel_conditioning.sv ----
// Receive signaling extractor and payload conditioner with APB registers
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rx_channel_conditioning #(
  parameter int NCH = rx_cond_pkg::NUM_CH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic [4:0]  rx_channel,
  input  wire logic [7:0]  rx_data,
  input  wire logic [3:0]  rx_sig,
  input  wire logic        rx_sig_update,
  input  wire logic        rx_sync,
  input  wire logic [1:0]  rx_format,
  input  wire logic        clock_master,
  output logic             out_valid,
  output logic [4:0]       out_channel,
  output logic [7:0]       out_data,
  output logic [3:0]       out_sig,
  output logic [7:0]       out_gap_mask,
  output logic             det_valid,
  output logic [7:0]       det_data,
  output logic             det_seven,
  output logic             gen_req,
  output logic             gen_seven,
  input  wire logic [7:0]  gen_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [NCH-1:0] ext_en_reg;
  logic [3:0]     ext_sig_reg [NCH];
  logic [7:0]     ctrl_reg [NCH];
  logic [7:0]     dtrk_reg [NCH];
  logic [6:0]     strk_reg [NCH];
  logic [7:0]     glb_reg;
  logic [2:0]     phase_reg;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic       bank;
  logic [7:0] idx;
  logic       setup;
  logic       wr;
  logic       hit_status;
  logic       hit_global;
  logic       hit_ext;
  logic       hit_ctrl;
  logic       hit_dtrk;
  logic       hit_strk;
  logic       mapped;
  logic [7:0] ch_ctrl;
  logic [7:0] ch_dtrk;
  logic [7:0] ch_strk;
  logic [4:0] sel_ch;
  logic [31:0] rd_next;

  assign bank = paddr[rx_cond_pkg::BANK_BIT];
  assign idx = paddr[9:2];
  assign setup = psel && !penable;
  // Zero wait states: every access phase completes at once
  assign pready = 1'b1;

  assign ch_ctrl = idx - rx_cond_pkg::BASE_CTRL;
  assign ch_dtrk = idx - rx_cond_pkg::BASE_DTRK;
  assign ch_strk = idx - rx_cond_pkg::BASE_STRK;

  always_comb
  begin
    hit_status = 1'b0;
    hit_global = 1'b0;
    hit_ext = 1'b0;
    hit_ctrl = 1'b0;
    hit_dtrk = 1'b0;
    hit_strk = 1'b0;
    sel_ch = 5'h0;
    // Address bit 11 must be clear and the access word aligned
    if (paddr[11] == 1'b0 && paddr[1:0] == 2'h0)
    begin
      if (bank == rx_cond_pkg::BANK_EXT)
      begin
        if (idx == rx_cond_pkg::IDX_STATUS)
        begin
          hit_status = 1'b1;
        end
        else if (ch_ctrl < 8'(NCH))
        begin
          hit_ext = 1'b1;
          sel_ch = ch_ctrl[4:0];
        end
      end
      else
      begin
        if (idx == rx_cond_pkg::IDX_GLOBAL)
        begin
          hit_global = 1'b1;
        end
        else if (ch_ctrl < 8'(NCH))
        begin
          hit_ctrl = 1'b1;
          sel_ch = ch_ctrl[4:0];
        end
        else if (ch_dtrk < 8'(NCH))
        begin
          hit_dtrk = 1'b1;
          sel_ch = ch_dtrk[4:0];
        end
        else if (ch_strk < 8'(NCH))
        begin
          hit_strk = 1'b1;
          sel_ch = ch_strk[4:0];
        end
      end
    end
  end

  assign mapped = hit_status || hit_global || hit_ext || hit_ctrl || hit_dtrk || hit_strk;
  assign wr = psel && penable && pwrite && mapped;
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    rd_next = 32'h0;
    if (hit_status)
    begin
      rd_next = {29'h0, rx_format, rx_sync};
    end
    else if (hit_global)
    begin
      rd_next = {24'h0, glb_reg};
    end
    else if (hit_ext)
    begin
      rd_next = {27'h0, ext_en_reg[sel_ch], ext_sig_reg[sel_ch]};
    end
    else if (hit_ctrl)
    begin
      rd_next = {24'h0, ctrl_reg[sel_ch]};
    end
    else if (hit_dtrk)
    begin
      rd_next = {24'h0, dtrk_reg[sel_ch]};
    end
    else if (hit_strk)
    begin
      rd_next = {25'h0, strk_reg[sel_ch]};
    end
  end

  // Read data is sampled in the setup cycle and held through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
    end
    else if (setup && !pwrite)
    begin
      prdata <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global control register

  logic [2:0] glb_sel;
  logic       glb_strk_en;
  logic       per_channel_clock_control_enable;
  logic [1:0] ptw_mode;
  logic       pt_dir;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      glb_reg <= rx_cond_pkg::GLB_RST;
    end
    else if (wr && hit_global)
    begin
      glb_reg <= pwdata[7:0];
    end
  end

  assign glb_sel = glb_reg[rx_cond_pkg::GLB_SEL_LSB +: 3];
  assign glb_strk_en = glb_reg[rx_cond_pkg::GLB_STRK_EN];
  assign per_channel_clock_control_enable = glb_reg[rx_cond_pkg::GLB_PER_CHANNEL_CLOCK_CONTROL_ENABLE];
  assign ptw_mode = glb_reg[rx_cond_pkg::GLB_PTW_LSB +: 2];
  assign pt_dir = glb_reg[rx_cond_pkg::GLB_PTDIR];

  ////////////////////////////////////////////////////////////////////////////
  // Signaling extractor

  logic       ch_ok;
  logic       sig_framed;
  logic       do_extract;
  logic [3:0] sig_fill;

  assign ch_ok = rx_valid && (rx_channel < 5'(NCH));
  // DM carries no signaling; only SF, ESF and SLC-96 qualify
  assign sig_framed = rx_sync && (rx_format != rx_cond_pkg::FMT_DM);
  assign do_extract = ch_ok && rx_sig_update && sig_framed && ext_en_reg[rx_channel];
  assign sig_fill = (rx_format == rx_cond_pkg::FMT_SF) ? {rx_sig[3:2], rx_sig[3:2]} : rx_sig;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_en_reg <= {NCH{rx_cond_pkg::EXT_EN_RST}};
    end
    else if (wr && hit_ext)
    begin
      // Software is expected to clear these in DM format
      ext_en_reg[sel_ch] <= pwdata[rx_cond_pkg::EXT_EN_BIT];
    end
  end

  // Fields hold stale content once extraction stops; read them only
  // while the enable is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ext_sig_reg[i] <= 4'h0;
      end
    end
    else if (do_extract)
    begin
      ext_sig_reg[rx_channel] <= sig_fill;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conditioner per-channel registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ctrl_reg[i] <= 8'h0;
        dtrk_reg[i] <= 8'h0;
        strk_reg[i] <= 7'h0;
      end
    end
    else if (wr)
    begin
      if (hit_ctrl)
      begin
        ctrl_reg[sel_ch] <= pwdata[7:0];
      end
      if (hit_dtrk)
      begin
        dtrk_reg[sel_ch] <= pwdata[7:0];
      end
      if (hit_strk)
      begin
        // Bit 5 is reserved and kept at zero
        strk_reg[sel_ch] <= {pwdata[6], 1'b0, pwdata[4:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Milliwatt phase advances once per frame

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= 3'h0;
    end
    else if (ch_ok && rx_channel == 5'(NCH - 1))
    begin
      phase_reg <= phase_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel datapath

  logic [7:0] cur_ctrl;
  logic [6:0] cur_strk;
  logic [2:0] eff_sel;
  logic       pt_mode_on;
  logic       pt_chan;
  logic       pt_detect;
  logic       pt_replace;
  logic [7:0] cond_data;
  logic [3:0] sig_next;
  logic [7:0] gap_next;
  logic       gap_allowed;

  assign cur_ctrl = ctrl_reg[rx_channel[4:0] < 5'(NCH) ? rx_channel : 5'h0];
  assign cur_strk = strk_reg[rx_channel[4:0] < 5'(NCH) ? rx_channel : 5'h0];

  // A nonzero global select overrides every channel
  assign eff_sel = (glb_sel == rx_cond_pkg::REPL_NONE)
                 ? cur_ctrl[rx_cond_pkg::CTRL_SEL_LSB +: 3] : glb_sel;

  assign pt_mode_on = (ptw_mode == rx_cond_pkg::PTW_8) || (ptw_mode == rx_cond_pkg::PTW_7);
  assign pt_chan = ch_ok && pt_mode_on && cur_strk[rx_cond_pkg::STRK_TEST_BIT];
  assign pt_detect = pt_chan && !pt_dir;
  assign pt_replace = pt_chan && pt_dir;

  // Each enabled channel pulls one generator word in timeslot order,
  // so the pattern runs on unbroken across channels
  assign gen_req = pt_replace;
  assign gen_seven = (ptw_mode == rx_cond_pkg::PTW_7);

  channel_conditioner u_cond (
    .din           (rx_data),
    .repl_sel      (eff_sel),
    .trunk_code    (dtrk_reg[rx_channel < 5'(NCH) ? rx_channel : 5'h0]),
    .mw_phase      (phase_reg),
    .msb_flip      (cur_ctrl[rx_cond_pkg::CTRL_MSB_FLIP]),
    .odd_bit_flip  (cur_ctrl[rx_cond_pkg::CTRL_ODD_FLIP]),
    .even_bit_flip (cur_ctrl[rx_cond_pkg::CTRL_EVEN_FLIP]),
    .pat_replace   (pt_replace),
    .pat_seven     (gen_seven),
    .pat_data      (gen_data),
    .dout          (cond_data)
  );

  assign sig_next = (cur_strk[rx_cond_pkg::STRK_EN_BIT] || glb_strk_en)
                  ? cur_strk[3:0] : rx_sig;

  assign gap_allowed = clock_master && per_channel_clock_control_enable;

  always_comb
  begin
    gap_next = 8'h00;
    if (gap_allowed)
    begin
      if (cur_ctrl[rx_cond_pkg::CTRL_CH_GAP])
      begin
        gap_next = rx_cond_pkg::MASK_ALL;
      end
      else if (cur_ctrl[rx_cond_pkg::CTRL_LSB_GAP])
      begin
        gap_next = rx_cond_pkg::MASK_LSB;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid <= 1'b0;
      out_channel <= 5'h0;
      out_data <= 8'h0;
      out_sig <= 4'h0;
      out_gap_mask <= 8'h0;
    end
    else
    begin
      out_valid <= ch_ok;
      if (ch_ok)
      begin
        out_channel <= rx_channel;
        out_data <= cond_data;
        out_sig <= sig_next;
        out_gap_mask <= gap_next;
      end
    end
  end

  // Detector sees the received byte before any conditioning
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      det_valid <= 1'b0;
      det_data <= 8'h0;
      det_seven <= 1'b0;
    end
    else
    begin
      det_valid <= pt_detect;
      if (pt_detect)
      begin
        det_data <= rx_data;
        det_seven <= gen_seven;
      end
    end
  end

endmodule : rx_channel_conditioning
`default_nettype wire

// ---- test/rx_cond_sva.sv ----
// Port checker for the receive channel conditioning block
`timescale 1ns/1ps
`default_nettype none
module rx_cond_sva #(
  parameter int NCH = 24
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_valid,
  input wire logic [4:0]  rx_channel,
  input wire logic [7:0]  rx_data,
  input wire logic        clock_master,
  input wire logic        out_valid,
  input wire logic [4:0]  out_channel,
  input wire logic [7:0]  out_data,
  input wire logic [7:0]  out_gap_mask,
  input wire logic        det_valid,
  input wire logic [7:0]  det_data,
  input wire logic        gen_req
);
  logic [7:0] reg_idx;
  logic       reg_known;
  logic       addr_bad;
  assign reg_idx = paddr[9:2];
  // Trunk code words exist in the conditioner bank only
  assign reg_known = (reg_idx == 8'h00) || (reg_idx >= 8'h01 && reg_idx <= 8'(NCH))
                   || (paddr[10] && reg_idx >= rx_cond_pkg::BASE_DTRK && reg_idx < rx_cond_pkg::BASE_DTRK + 8'(NCH))
                   || (paddr[10] && reg_idx >= rx_cond_pkg::BASE_STRK && reg_idx < rx_cond_pkg::BASE_STRK + 8'(NCH));
  assign addr_bad = paddr[11] || (paddr[1:0] != 2'b00) || !reg_known;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  a_out_follows: assert property (rx_valid && rx_channel < NCH |=>
    out_valid && out_channel == $past(rx_channel))
    else $error("no output byte for accepted channel");
  a_out_quiet: assert property (!(rx_valid && rx_channel < NCH) |=> !out_valid)
    else $error("output byte without accepted input");
  a_out_hold: assert property (!out_valid |-> $stable(out_data) && $stable(out_gap_mask))
    else $error("output changed between bytes");
  a_det_raw: assert property (det_valid |-> $past(rx_valid) && det_data == $past(rx_data))
    else $error("detector byte not the received byte");
  a_gen_slot: assert property (gen_req |-> rx_valid && rx_channel < NCH)
    else $error("generator request outside a timeslot");
  a_dir_excl: assert property (det_valid |-> !$past(gen_req))
    else $error("byte both detected and overwritten");
  a_gap_master: assert property (out_valid && !$past(clock_master) |-> out_gap_mask == 8'h00)
    else $error("gap mask outside clock master mode");
  a_gap_shape: assert property (out_valid |-> out_gap_mask inside {8'h00, 8'h01, 8'hff})
    else $error("gap mask has illegal shape");
  a_pready_on: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  a_slverr_map: assert property (psel && penable |-> pslverr == addr_bad)
    else $error("error response on wrong address");
  c_out: cover property (out_valid && out_gap_mask == 8'hff);
  c_det: cover property (det_valid);
  c_gen: cover property (gen_req);
endmodule : rx_cond_sva
bind rx_channel_conditioning rx_cond_sva #(.NCH(NCH)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
  .rx_channel(rx_channel), .rx_data(rx_data), .clock_master(clock_master), .out_valid(out_valid),
  .out_channel(out_channel), .out_data(out_data), .out_gap_mask(out_gap_mask), .det_valid(det_valid),
  .det_data(det_data), .gen_req(gen_req));
`default_nettype wire

// ---- test/pattern_source.sv ----
// Test pattern generator standing on the backplane side
`timescale 1ns/1ps
`default_nettype none
module pattern_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       gen_req,
  output logic      [7:0] gen_data
);
  logic [7:0] lfsr_reg;
  // Advances only when consumed, so replaced channels form one stream
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lfsr_reg <= 8'h5a;
    else if (gen_req)
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
  end
  // Not held outside a request, so a late sample sees a wrong word
  assign gen_data = gen_req ? lfsr_reg : ~lfsr_reg;
endmodule : pattern_source
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the receive channel conditioning block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, co;
  logic [31:0] pwdata, prdata, seed, rd;
  logic        rx_valid, rx_sig_update, rx_sync, clock_master;
  logic        out_valid, det_valid, det_seven, gen_req, gen_seven;
  logic [4:0]  rx_channel, out_channel, ch;
  logic [7:0]  rx_data, out_data, out_gap_mask, det_data, gen_data;
  logic [7:0]  glb, ctl, dtk, stk, d, g, x, gm;
  logic [3:0]  rx_sig, out_sig, s;
  logic [3:0]  sig_m [24];
  logic [1:0]  rx_format, fm, pm;
  logic [2:0]  sel;
  logic [63:0] mw;
  logic        u, sy, cm, en, on, gr, err;
  int          n_fail, n_tests, cyc, n23;
  logic [11:0] ra [10] = '{12'h004, 12'h400, 12'h404, 12'h484, 12'h504, 12'h000, 12'h800, 12'h406, 12'h064, 12'h4e4};
  logic [7:0]  rv [10] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        ek [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  rx_channel_conditioning dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_channel, .rx_data, .rx_sig, .rx_sig_update, .rx_sync, .rx_format,
    .clock_master, .out_valid, .out_channel, .out_data, .out_sig, .out_gap_mask, .det_valid, .det_data,
    .det_seven, .gen_req, .gen_seven, .gen_data);
  pattern_source src_u (.pclk, .presetn, .gen_req, .gen_data);
  ////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Whole run needs about 4800 cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      final_report;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic send;
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_channel <= ch;
    rx_data <= d;
    rx_sig <= s;
    rx_sig_update <= u;
    rx_sync <= sy;
    rx_format <= fm;
    clock_master <= cm;
    #1;
    g = gen_data;
    gr = gen_req;
    @(posedge pclk);
    rx_valid <= 1'b0;
    #1;
  endtask : send
  task automatic final_report;
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, rx_valid, rx_channel, rx_data, rx_sig, rx_sig_update} = '0;
    // Framer synchronized in ESF, clock slave, reset asserted
    {rx_sync, rx_format, clock_master, presetn} = 5'b10100;
    seed = 32'h0000d2d7;
    foreach (sig_m[k]) sig_m[k] = 4'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 10; k++)
    begin
      apb(1'b0, ra[k], 8'h00);
      check("reset or map read", rd, {24'h0, rv[k]});
      check("slave error", err, ek[k]);
    end
    apb(1'b1, 12'h504, 8'hff);
    apb(1'b0, 12'h504, 8'h00);
    check("signaling trunk reserved bits", rd, 32'h5f);
    for (int i = 0; i < 250; i++)
    begin
      seed = xs(seed);
      {glb, ctl, dtk, stk} = seed;
      if (i % 2 == 0)
        glb[2:0] = 3'h0;
      seed = xs(seed);
      {ch, d, s, u, sy, cm, en, fm} = seed[22:0];
      ch = ch % 5'h1a;
      co = {5'h0, ch, 2'h0};
      if (ch < 24)
      begin
        if (fm == 2'h2)
          en = 1'b0;
        apb(1'b1, 12'h400, glb);
        apb(1'b1, 12'h404 + co, ctl);
        apb(1'b1, 12'h484 + co, dtk);
        apb(1'b1, 12'h504 + co, stk);
        apb(1'b1, 12'h004 + co, {3'h0, en, 4'h0});
      end
      send;
      if (ch >= 24)
      begin
        check("refused channel", {out_valid, det_valid, gr}, 3'h0);
        continue;
      end
      sel = glb[2:0] != 3'h0 ? glb[2:0] : ctl[7:5];
      mw = sel == 3'h2 ? rx_cond_pkg::MW_ALAW : rx_cond_pkg::MW_ULAW;
      x = sel == 3'h1 ? dtk : (sel == 3'h2 || sel == 3'h3) ? mw[63 - 8 * (n23 % 8) -: 8] : d;
      x = x ^ ({8{ctl[4]}} & 8'h80) ^ ({8{ctl[3]}} & 8'h2a) ^ ({8{ctl[2]}} & 8'h55);
      pm = glb[6:5];
      on = (pm == 2'h1 || pm == 2'h2) && stk[6];
      if (on && glb[7])
        x = pm == 2'h2 ? {g[6:0], x[0]} : g;
      gm = (cm && glb[4]) ? (ctl[0] ? 8'hff : {7'h0, ctl[1]}) : 8'h00;
      check("out valid and channel", {out_valid, out_channel}, {1'b1, ch});
      check("out data", out_data, x);
      check("gap mask", out_gap_mask, gm);
      check("generator request", gr, on && glb[7]);
      check("detector", {det_valid, det_valid ? det_data : 8'h00}, {on && !glb[7], on && !glb[7] ? d : 8'h00});
      if (on && !glb[7])
        check("detector width", det_seven, pm == 2'h2);
      check("generator width", gen_seven, pm == 2'h2);
      check("signaling out", out_sig, (stk[4] || glb[3]) ? stk[3:0] : s);
      if (en && sy && fm != 2'h2 && u)
        sig_m[ch] = fm == 2'h0 ? {s[3:2], s[3:2]} : s;
      if (ch == 5'd23)
        n23++;
      apb(1'b0, 12'h004 + co, 8'h00);
      check("extract register", rd, en ? {27'h1, sig_m[ch]} : {27'h0, rd[3:0]});
    end
    final_report;
  end
endmodule : tb_top
`default_nettype wire
